// ===== src/abr_ctrl.sv
/*
 * Acquisition controller: busy generation and combination, data, software
 * and hardware reset, fast-clear window and event buffer pointer tracking.
 * Assumes panel signals and crate lines are asynchronous, the register port
 * is synchronous to clk, and arst_n is power-on or bus system reset.
 */
`timescale 1ns/1ps
module abr_ctrl import abr_pkg::*; #(
    parameter int CONFIG_CYC = ABR_CONFIG_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic window_in,
    input wire logic common_window_in,
    input wire logic fast_abort_in,
    input wire logic front_reset_in,
    input wire logic inhibit_in,
    input wire logic hold_mode_jumper,
    input wire logic hold_or_in,
    output logic hold_or_out,
    output logic hold_or_oe_n,
    input wire logic hold_nand_in,
    output logic hold_nand_out,
    output logic hold_nand_oe_n,
    output logic busy_out,
    output logic busy_led,
    output logic data_present_led,
    output logic integrator_clear,
    output logic conv_active
);

    logic [ABR_IN_W-1:0] raw_in;
    logic [ABR_IN_W-1:0] sync1_r;
    logic [ABR_IN_W-1:0] sync2_r;
    logic [ABR_IN_W-1:0] sync3_r;
    logic [ABR_IN_W-1:0] stable_r;
    logic [ABR_IN_W-1:0] stable_d_r;
    logic win_rise;
    logic abort_rise;
    logic reset_rise;
    logic inhibit_lvl;
    logic abort_lvl;
    logic shared_sel;
    logic or_line;
    logic nand_line;

    logic [15:0] ctrl1_r;
    logic [15:0] fcwin_r;
    logic soft_bit_r;
    logic data_clr_r;
    logic [ABR_PTR_W-1:0] wr_ptr_r;
    logic [ABR_PTR_W-1:0] rd_ptr_r;
    logic last_wr_r;
    logic [ABR_EVCNT_W-1:0] evcnt_r;
    logic [15:0] cnt_r;
    logic [15:0] cfg_cnt_r;
    logic cfg_busy_r;
    logic busy_r;
    logic [15:0] rdata_r;
    abr_state_type state_r;
    abr_state_type state_nxt;

    logic ssr_wr;
    logic rd_adv_wr;
    logic soft_rst;
    logic data_rst;
    logic buf_full;
    logic buf_empty;
    logic present;
    logic mem_test;
    logic busy_local;
    logic hold;
    logic accept;
    logic abort_ok;
    logic conv_done;
    logic clear_done;

    // Window and common window form one integration window
    assign raw_in[ABR_IN_WIN] = window_in | common_window_in;
    assign raw_in[ABR_IN_ABORT] = fast_abort_in;
    assign raw_in[ABR_IN_RESET] = front_reset_in;
    assign raw_in[ABR_IN_INHIBIT] = inhibit_in;
    assign raw_in[ABR_IN_JUMPER] = hold_mode_jumper;
    assign raw_in[ABR_IN_OR_LINE] = hold_or_in;
    assign raw_in[ABR_IN_NAND_LINE] = hold_nand_in;

    // Three-stage synchroniser; a level counts once stages two and three agree
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stable_r <= '0;
            stable_d_r <= '0;
        end else begin
            for (int i = 0; i < ABR_IN_W; i++) begin
                if (sync2_r[i] == sync3_r[i]) begin
                    stable_r[i] <= sync3_r[i];
                end
            end
            stable_d_r <= stable_r;
        end
    end

    // Leading edges of the panel pulses
    assign win_rise = stable_r[ABR_IN_WIN] & ~stable_d_r[ABR_IN_WIN];
    assign abort_rise = stable_r[ABR_IN_ABORT] & ~stable_d_r[ABR_IN_ABORT];
    assign reset_rise = stable_r[ABR_IN_RESET] & ~stable_d_r[ABR_IN_RESET];
    assign inhibit_lvl = stable_r[ABR_IN_INHIBIT];
    assign abort_lvl = stable_r[ABR_IN_ABORT];
    assign shared_sel = stable_r[ABR_IN_JUMPER];
    assign or_line = stable_r[ABR_IN_OR_LINE];
    assign nand_line = stable_r[ABR_IN_NAND_LINE];

    // Register strobes with side effects
    assign ssr_wr = reg_wr && (reg_addr == ABR_OFS_SSRESET);
    assign rd_adv_wr = reg_wr && (reg_addr == ABR_OFS_RD_ADV);

    // Reset levels
    assign soft_rst = soft_bit_r
        | ssr_wr
        | (reset_rise & ctrl1_r[ABR_CTRL1_SCOPE]);
    assign data_rst = soft_rst
        | data_clr_r
        | (reset_rise & ~ctrl1_r[ABR_CTRL1_SCOPE]);

    // Event buffer state
    assign buf_full = (wr_ptr_r == rd_ptr_r) & last_wr_r;
    assign buf_empty = (wr_ptr_r == rd_ptr_r) & ~last_wr_r;
    assign present = ~buf_empty;
    assign mem_test = ctrl1_r[ABR_CTRL1_MEMTEST];

    // Busy sources and stop rule
    assign busy_local = (state_r != ABR_ST_IDLE) | (state_nxt != ABR_ST_IDLE)
        | buf_full | mem_test | data_rst;
    assign hold = shared_sel ? (busy_r | or_line) : busy_r;
    assign accept = (state_r == ABR_ST_IDLE) & win_rise
        & ~inhibit_lvl & ~abort_lvl & ~hold & ~data_rst;
    assign abort_ok = (state_r == ABR_ST_CONV) & abort_rise
        & (cnt_r <= fcwin_r);
    assign conv_done = (state_r == ABR_ST_CONV) & ~abort_ok
        & (cnt_r == 16'(ABR_CONV_CYC - 1));
    assign clear_done = (state_r == ABR_ST_CLEAR) & (cnt_r == 16'(ABR_CLEAR_CYC - 1));

    // Acquisition sequence
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ABR_ST_IDLE: begin
                if (accept) begin
                    state_nxt = ABR_ST_CONV;
                end
            end
            ABR_ST_CONV: begin
                if (abort_ok) begin
                    state_nxt = ABR_ST_CLEAR;
                end else if (conv_done) begin
                    state_nxt = ABR_ST_IDLE;
                end
            end
            ABR_ST_CLEAR: begin
                if (clear_done) begin
                    state_nxt = ABR_ST_IDLE;
                end
            end
            ABR_ST_ARST: begin
                if (!data_rst) begin
                    state_nxt = ABR_ST_IDLE;
                end
            end
            default: begin
                state_nxt = ABR_ST_IDLE;
            end
        endcase
        if (data_rst) begin
            state_nxt = ABR_ST_ARST;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ABR_ST_ARST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Cycle counter for conversion and clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
        end else if (state_nxt != state_r) begin
            cnt_r <= '0;
        end else if (state_r == ABR_ST_CONV || state_r == ABR_ST_CLEAR) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // Soft-resettable control registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl1_r <= ABR_CTRL1_RST;
            fcwin_r <= ABR_FCWIN_RST;
        end else if (soft_rst) begin
            ctrl1_r <= ABR_CTRL1_RST;
            fcwin_r <= ABR_FCWIN_RST;
        end else if (reg_wr) begin
            if (reg_addr == ABR_OFS_CTRL1) begin
                ctrl1_r <= reg_wdata;
            end else if (reg_addr == ABR_OFS_FCWIN) begin
                fcwin_r <= reg_wdata;
            end
        end
    end

    // Hardware-only bit-set registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            soft_bit_r <= 1'b0;
            data_clr_r <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == ABR_OFS_BSET1 && reg_wdata[ABR_BSET1_SOFT]) begin
                soft_bit_r <= 1'b1;
            end else if (reg_addr == ABR_OFS_BCLR1 && reg_wdata[ABR_BSET1_SOFT]) begin
                soft_bit_r <= 1'b0;
            end else if (reg_addr == ABR_OFS_BSET2 && reg_wdata[ABR_BSET2_DATA_CLR]) begin
                data_clr_r <= 1'b1;
            end else if (reg_addr == ABR_OFS_BCLR2 && reg_wdata[ABR_BSET2_DATA_CLR]) begin
                data_clr_r <= 1'b0;
            end
        end
    end

    // Event buffer pointers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            last_wr_r <= 1'b0;
        end else if (data_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            last_wr_r <= 1'b0;
        end else begin
            if (conv_done) begin
                wr_ptr_r <= wr_ptr_r + 5'h01;
            end
            if (rd_adv_wr && !buf_empty) begin
                rd_ptr_r <= rd_ptr_r + 5'h01;
            end
            if (conv_done && !(rd_adv_wr && !buf_empty)) begin
                last_wr_r <= 1'b1;
            end else if (!conv_done && rd_adv_wr && !buf_empty) begin
                last_wr_r <= 1'b0;
            end
        end
    end

    // Accepted window counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            evcnt_r <= '0;
        end else if (data_rst) begin
            evcnt_r <= '0;
        end else if (accept) begin
            evcnt_r <= evcnt_r + 24'h000001;
        end
    end

    // Power-on configuration phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_cnt_r <= '0;
            cfg_busy_r <= 1'b1;
        end else if (cfg_busy_r) begin
            cfg_cnt_r <= cfg_cnt_r + 16'h0001;
            if (cfg_cnt_r == 16'(CONFIG_CYC - 1)) begin
                cfg_busy_r <= 1'b0;
            end
        end
    end

    // Registered busy and lamps
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_r <= 1'b1;
            busy_led <= 1'b1;
            data_present_led <= 1'b1;
            integrator_clear <= 1'b1;
            conv_active <= 1'b0;
        end else begin
            busy_r <= busy_local;
            busy_led <= busy_local | cfg_busy_r;
            data_present_led <= present | cfg_busy_r;
            integrator_clear <= (state_nxt == ABR_ST_CLEAR)
                | (state_nxt == ABR_ST_ARST);
            conv_active <= (state_nxt == ABR_ST_CONV);
        end
    end

    assign busy_out = busy_r;

    // Crate lines: OR line pulled high, NAND line pulled low while busy
    assign hold_or_out = 1'b1;
    assign hold_or_oe_n = ~busy_r;
    assign hold_nand_out = 1'b0;
    assign hold_nand_oe_n = ~busy_r;

    // Register read port, data valid the cycle after the strobe only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= '0;
        end else if (!reg_rd) begin
            rdata_r <= '0;
        end else if (reg_addr == ABR_OFS_STATUS1) begin
            rdata_r <= '0;
            rdata_r[ABR_ST1_PRESENT] <= present;
            rdata_r[ABR_ST1_EMPTY] <= buf_empty;
            rdata_r[ABR_ST1_BUSY] <= busy_r;
            rdata_r[ABR_ST1_CRATE_HOLD] <= or_line;
            rdata_r[ABR_ST1_NAND_LINE] <= nand_line;
            rdata_r[ABR_ST1_FULL] <= buf_full;
            rdata_r[ABR_ST1_CONFIG] <= cfg_busy_r;
        end else if (reg_addr == ABR_OFS_CTRL1) begin
            rdata_r <= ctrl1_r;
        end else if (reg_addr == ABR_OFS_BSET1 || reg_addr == ABR_OFS_BCLR1) begin
            rdata_r <= '0;
            rdata_r[ABR_BSET1_SOFT] <= soft_bit_r;
        end else if (reg_addr == ABR_OFS_BSET2 || reg_addr == ABR_OFS_BCLR2) begin
            rdata_r <= '0;
            rdata_r[ABR_BSET2_DATA_CLR] <= data_clr_r;
        end else if (reg_addr == ABR_OFS_FCWIN) begin
            rdata_r <= fcwin_r;
        end else if (reg_addr == ABR_OFS_EVCNT_LO) begin
            rdata_r <= evcnt_r[15:0];
        end else if (reg_addr == ABR_OFS_EVCNT_HI) begin
            rdata_r <= {8'h00, evcnt_r[23:16]};
        end else if (reg_addr == ABR_OFS_PTRS) begin
            rdata_r <= {3'h0, rd_ptr_r, 3'h0, wr_ptr_r};
        end else begin
            rdata_r <= '0;
        end
    end

    assign reg_rdata = rdata_r;

endmodule

// ===== src/abr_pkg.sv
/*
 * Constants for the acquisition busy, reset and fast-clear controller:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 10 MHz system clock and a plain strobe register port.
 */
package abr_pkg;

    // Register offsets
    localparam logic [3:0] ABR_OFS_STATUS1 = 4'h0;
    localparam logic [3:0] ABR_OFS_CTRL1 = 4'h1;
    localparam logic [3:0] ABR_OFS_BSET1 = 4'h2;
    localparam logic [3:0] ABR_OFS_BCLR1 = 4'h3;
    localparam logic [3:0] ABR_OFS_BSET2 = 4'h4;
    localparam logic [3:0] ABR_OFS_BCLR2 = 4'h5;
    localparam logic [3:0] ABR_OFS_SSRESET = 4'h6;
    localparam logic [3:0] ABR_OFS_FCWIN = 4'h7;
    localparam logic [3:0] ABR_OFS_EVCNT_LO = 4'h8;
    localparam logic [3:0] ABR_OFS_EVCNT_HI = 4'h9;
    localparam logic [3:0] ABR_OFS_RD_ADV = 4'hA;
    localparam logic [3:0] ABR_OFS_PTRS = 4'hB;

    // Field positions
    localparam int ABR_ST1_PRESENT = 0;
    localparam int ABR_ST1_EMPTY = 1;
    localparam int ABR_ST1_BUSY = 2;
    localparam int ABR_ST1_CRATE_HOLD = 3;
    localparam int ABR_ST1_NAND_LINE = 4;
    localparam int ABR_ST1_FULL = 5;
    localparam int ABR_ST1_CONFIG = 6;
    localparam int ABR_CTRL1_SCOPE = 4;
    localparam int ABR_CTRL1_MEMTEST = 6;
    localparam int ABR_BSET1_SOFT = 7;
    localparam int ABR_BSET2_DATA_CLR = 2;

    // Reset values
    localparam logic [15:0] ABR_CTRL1_RST = 16'h0000;
    localparam logic [15:0] ABR_FCWIN_RST = 16'h0010;

    // Widths
    localparam int ABR_PTR_W = 5;
    localparam int ABR_EVCNT_W = 24;

    // Timing
    localparam int ABR_CLK_PERIOD_NS = 100;
    localparam int ABR_CONV_TIME_NS = 5700;
    localparam int ABR_CLEAR_TIME_NS = 600;
    localparam int ABR_CONFIG_TIME_NS = 1000000;
    localparam int ABR_CONV_CYC = (ABR_CONV_TIME_NS + ABR_CLK_PERIOD_NS - 1) / ABR_CLK_PERIOD_NS;
    localparam int ABR_CLEAR_CYC =
        (ABR_CLEAR_TIME_NS + ABR_CLK_PERIOD_NS - 1) / ABR_CLK_PERIOD_NS;
    localparam int ABR_CONFIG_CYC =
        (ABR_CONFIG_TIME_NS + ABR_CLK_PERIOD_NS - 1) / ABR_CLK_PERIOD_NS;

    // Sync vector bit positions
    localparam int ABR_IN_WIN = 0;
    localparam int ABR_IN_ABORT = 1;
    localparam int ABR_IN_RESET = 2;
    localparam int ABR_IN_INHIBIT = 3;
    localparam int ABR_IN_JUMPER = 4;
    localparam int ABR_IN_OR_LINE = 5;
    localparam int ABR_IN_NAND_LINE = 6;
    localparam int ABR_IN_W = 7;

    typedef enum logic [1:0] {
        ABR_ST_IDLE,
        ABR_ST_CONV,
        ABR_ST_CLEAR,
        ABR_ST_ARST
    } abr_state_type;

endpackage

// ===== tb/abr_ctrl_monitor.sv
/*
 * Port checks for the acquisition controller.
 * Assumes it is bound into abr_ctrl, one clock domain.
 */
`timescale 1ns/1ps
module abr_ctrl_monitor import abr_pkg::*; #(
    parameter int CONFIG_CYC = ABR_CONFIG_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic inhibit_in,
    input wire logic hold_mode_jumper,
    input wire logic hold_or_in,
    input wire logic hold_or_out,
    input wire logic hold_or_oe_n,
    input wire logic hold_nand_out,
    input wire logic hold_nand_oe_n,
    input wire logic busy_out,
    input wire logic busy_led,
    input wire logic data_present_led,
    input wire logic integrator_clear,
    input wire logic conv_active
);
    logic [7:0] clen_r;
    logic [3:0] blk_r;
    int cfg_r;
    logic blocked;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    assign blocked = inhibit_in || (hold_mode_jumper && hold_or_in);
    // Conversion length, blocked run length, cycles since reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clen_r <= 8'h00;
            blk_r <= 4'h0;
            cfg_r <= 0;
        end else begin
            clen_r <= conv_active ? clen_r + 8'h01 : 8'h00;
            blk_r <= !blocked ? 4'h0 : ((blk_r == 4'hF) ? blk_r : blk_r + 4'h1);
            cfg_r <= (cfg_r < CONFIG_CYC) ? cfg_r + 1 : cfg_r;
        end
    end
    property p_line_drive;
        hold_or_out && !hold_nand_out && hold_or_oe_n == !busy_out && hold_nand_oe_n == !busy_out;
    endproperty
    a_line_drive: assert property (p_line_drive) else $error("crate line drive wrong");
    property p_conv_busy;
        conv_active |-> busy_out;
    endproperty
    a_conv_busy: assert property (p_conv_busy) else $error("converting but not busy");
    property p_conv_len;
        $fell(conv_active) && !integrator_clear |-> clen_r == ABR_CONV_CYC;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
    property p_no_restart;
        $rose(conv_active) |-> !$past(busy_out);
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("start while busy");
    property p_clear_gap;
        $rose(integrator_clear) |-> !conv_active [*3];
    endproperty
    a_clear_gap: assert property (p_clear_gap) else $error("start during clear");
    property p_blocked;
        $rose(conv_active) |-> blk_r < 4'hC;
    endproperty
    a_blocked: assert property (p_blocked) else $error("start while blocked");
    property p_led;
        busy_out |-> busy_led;
    endproperty
    a_led: assert property (p_led) else $error("busy lamp off while busy");
    property p_config;
        cfg_r < CONFIG_CYC - 1 |-> busy_led && data_present_led;
    endproperty
    a_config: assert property (p_config) else $error("lamps off in config phase");
    property p_status_busy;
        $past(reg_rd) && $past(reg_addr) == ABR_OFS_STATUS1 |->
            reg_rdata[ABR_ST1_BUSY] == $past(busy_out);
    endproperty
    a_status_busy: assert property (p_status_busy) else $error("status busy bit wrong");
endmodule
bind abr_ctrl abr_ctrl_monitor #(.CONFIG_CYC(CONFIG_CYC)) abr_ctrl_monitor_i (
    .clk, .arst_n, .reg_addr, .reg_rd, .reg_rdata, .inhibit_in, .hold_mode_jumper,
    .hold_or_in, .hold_or_out, .hold_or_oe_n, .hold_nand_out, .hold_nand_oe_n,
    .busy_out, .busy_led, .data_present_led, .integrator_clear, .conv_active
);

// ===== tb/abr_ctrl_tb.sv
/*
 * Self-checking bench for the acquisition controller with a counting model.
 * Assumes the trigger and crate model in abr_partner.
 */
`timescale 1ns/1ps
module abr_ctrl_tb import abr_pkg::*;;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic hold_mode_jumper = 1'b0;
    logic [15:0] reg_rdata;
    logic [4:0] pin;
    logic hold_or_in, hold_nand_in, hold_or_oe_n, hold_nand_oe_n;
    logic busy_out, data_present_led, integrator_clear, conv_active;
    int fails = 0;
    int samples_checked = 0;
    int seed = 32'hA233;
    int ev = 0;
    int wp = 0;
    int rp = 0;
    int n;
    logic [15:0] v;
    logic [15:0] fc;
    always #50 clk = ~clk;
    abr_ctrl #(.CONFIG_CYC(8)) abr_ctrl_i (
        .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .window_in(pin[0]), .common_window_in(pin[1]), .fast_abort_in(pin[2]),
        .front_reset_in(pin[3]), .inhibit_in(pin[4]), .hold_mode_jumper,
        .hold_or_in, .hold_or_out(), .hold_or_oe_n, .hold_nand_in, .hold_nand_out(),
        .hold_nand_oe_n, .busy_out, .busy_led(), .data_present_led, .integrator_clear,
        .conv_active
    );
    abr_partner abr_partner_i (.clk, .hold_or_oe_n, .hold_nand_oe_n, .pin, .hold_or_in,
        .hold_nand_in);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
        @(posedge clk);
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    // Bounded wait on settled outputs: 0 busy, 1 converting, 2 integrator clear, 3 data lamp
    task automatic ws(input int s, input logic e);
        logic [3:0] o;
        int k;
        for (k = 0; k < 400; k++) begin
            @(negedge clk);
            o = {data_present_led, integrator_clear, conv_active, busy_out};
            if (o[s] === e) break;
        end
        chk(o[s], e);
        @(posedge clk);
    endtask
    // One settled look at the same outputs
    task automatic cn(input int s, input logic e);
        logic [3:0] o;
        @(negedge clk);
        o = {data_present_led, integrator_clear, conv_active, busy_out};
        chk(o[s], e);
        @(posedge clk);
    endtask
    task automatic mdl;
        rc(ABR_OFS_EVCNT_LO, ev[15:0]);
        rc(ABR_OFS_PTRS, {3'h0, rp[4:0], 3'h0, wp[4:0]});
    endtask
    task automatic trig(input int i, input bit acc);
        abr_partner_i.pulse(i, 4);
        if (acc) begin
            ev++;
            ws(1, 1'b1);
            ws(1, 1'b0);
            wp++;
            ws(0, (wp - rp) == 32);
        end else begin
            repeat (12) @(posedge clk);
            cn(1, 1'b0);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report;
    end
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rc(ABR_OFS_CTRL1, ABR_CTRL1_RST);
        rc(ABR_OFS_FCWIN, ABR_FCWIN_RST);
        rc(4'hC, 16'h0000);
        ws(0, 1'b0);
        trig(0, 1'b1);
        cn(3, 1'b1);
        trig(1, 1'b1);
        abr_partner_i.pulse(0, 4);
        ws(1, 1'b1);
        abr_partner_i.pulse(1, 4);
        ev++;
        ws(1, 1'b0);
        wp++;
        trig(0, 1'b1);
        mdl;
        abr_partner_i.level(4, 1'b1);
        trig(0, 1'b0);
        abr_partner_i.level(4, 1'b0);
        repeat (6) @(posedge clk);
        fc = 16'h0008 + 16'($random(seed) & 32'h7);
        wr(ABR_OFS_FCWIN, fc);
        rc(ABR_OFS_FCWIN, fc);
        abr_partner_i.pulse(0, 4);
        abr_partner_i.pulse(2, 3);
        ev++;
        ws(2, 1'b1);
        trig(0, 1'b0);
        ws(2, 1'b0);
        trig(0, 1'b1);
        wr(ABR_OFS_FCWIN, 16'h0001);
        abr_partner_i.pulse(0, 4);
        repeat (8) @(posedge clk);
        abr_partner_i.pulse(2, 3);
        ev++;
        ws(1, 1'b0);
        wp++;
        mdl;
        hold_mode_jumper <= 1'b1;
        abr_partner_i.crate(1'b1);
        repeat (6) @(posedge clk);
        rd(ABR_OFS_STATUS1, v);
        chk(v[ABR_ST1_CRATE_HOLD], 1'b1);
        chk(v[ABR_ST1_NAND_LINE], 1'b0);
        trig(0, 1'b0);
        hold_mode_jumper <= 1'b0;
        repeat (6) @(posedge clk);
        trig(0, 1'b1);
        abr_partner_i.crate(1'b0);
        abr_partner_i.pulse(0, 4);
        ws(1, 1'b1);
        abr_partner_i.pulse(3, 4);
        ws(1, 1'b0);
        ev = 0;
        wp = 0;
        rp = 0;
        ws(0, 1'b0);
        mdl;
        rc(ABR_OFS_FCWIN, 16'h0001);
        wr(ABR_OFS_CTRL1, 16'h0010);
        abr_partner_i.pulse(3, 4);
        ws(0, 1'b1);
        ws(0, 1'b0);
        rc(ABR_OFS_CTRL1, ABR_CTRL1_RST);
        rc(ABR_OFS_FCWIN, ABR_FCWIN_RST);
        trig(0, 1'b1);
        wr(ABR_OFS_BSET2, 16'h0004);
        ev = 0;
        wp = 0;
        ws(0, 1'b1);
        trig(0, 1'b0);
        mdl;
        wr(ABR_OFS_BCLR2, 16'h0004);
        ws(0, 1'b0);
        wr(ABR_OFS_BSET1, 16'h0080);
        wr(ABR_OFS_FCWIN, 16'h0005);
        rc(ABR_OFS_FCWIN, ABR_FCWIN_RST);
        cn(0, 1'b1);
        wr(ABR_OFS_BCLR1, 16'h0080);
        wr(ABR_OFS_FCWIN, 16'h0005);
        rc(ABR_OFS_FCWIN, 16'h0005);
        wr(ABR_OFS_SSRESET, 16'h0000);
        rc(ABR_OFS_FCWIN, ABR_FCWIN_RST);
        wr(ABR_OFS_FCWIN, 16'h0005);
        rc(ABR_OFS_FCWIN, 16'h0005);
        wr(ABR_OFS_CTRL1, 16'h0040);
        ws(0, 1'b1);
        trig(0, 1'b0);
        wr(ABR_OFS_CTRL1, 16'h0000);
        ws(0, 1'b0);
        for (n = 0; n < 32; n++) begin
            trig(0, 1'b1);
            repeat ($random(seed) & 3) @(posedge clk);
        end
        rd(ABR_OFS_STATUS1, v);
        chk(v[ABR_ST1_FULL], 1'b1);
        trig(0, 1'b0);
        mdl;
        for (n = 0; n < 33; n++) begin
            wr(ABR_OFS_RD_ADV, 16'h0000);
            rp = (rp < wp) ? rp + 1 : rp;
        end
        cn(0, 1'b0);
        cn(3, 1'b0);
        mdl;
        wr(ABR_OFS_FCWIN, 16'h0007);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        ev = 0;
        wp = 0;
        rp = 0;
        rc(ABR_OFS_FCWIN, ABR_FCWIN_RST);
        mdl;
        final_report;
    end
endmodule

// ===== tb/abr_partner.sv
/*
 * Model of the trigger electronics and the crate hold lines.
 * Assumes the bench calls its tasks right after a rising clock edge.
 */
`timescale 1ns/1ps
module abr_partner (
    input wire logic clk,
    input wire logic hold_or_oe_n,
    input wire logic hold_nand_oe_n,
    output logic [4:0] pin,
    output logic hold_or_in,
    output logic hold_nand_in
);
    logic other_busy;
    initial begin
        pin = 5'h00;
        other_busy = 1'b0;
    end
    // Pins: 0 window, 1 common window, 2 abort, 3 reset, 4 inhibit
    task automatic pulse(input int i, input int n);
        pin[i] <= 1'b1;
        repeat (n) @(posedge clk);
        pin[i] <= 1'b0;
    endtask
    task automatic level(input int i, input logic v);
        pin[i] <= v;
    endtask
    task automatic crate(input logic v);
        other_busy <= v;
    endtask
    // Wired-OR pulled low, wired-NAND pulled high when undriven
    assign hold_or_in = other_busy | ~hold_or_oe_n;
    assign hold_nand_in = ~(other_busy | ~hold_nand_oe_n);
endmodule
